// ---- design/chan_cfg_pkg.sv ----
// Purpose: Shared constants for the channel configuration register bank
// Assumes: Byte-wide registers reached by an 8-bit address from the control port
// Notes: Volume and gain trim encodings are half-dB and tenth-dB steps

package chan_cfg_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] OFF_CHAN_ONE_VOLUME = 8'h3E;
	localparam logic [7:0] OFF_CHAN_ONE_GAIN_TRIM = 8'h3F;
	localparam logic [7:0] OFF_CHAN_ONE_PHASE_TRIM = 8'h40;
	localparam logic [7:0] OFF_CHAN_TWO_INPUT_SETUP = 8'h41;

	// Reset values
	localparam logic [7:0] RST_CHAN_ONE_VOLUME = 8'hC9;
	localparam logic [7:0] RST_CHAN_ONE_GAIN_TRIM = 8'h80;
	localparam logic [7:0] RST_CHAN_ONE_PHASE_TRIM = 8'h00;
	localparam logic [7:0] RST_CHAN_TWO_INPUT_SETUP = 8'h00;

	// Writable bit masks; reserved bits read zero
	localparam logic [7:0] MASK_GAIN_TRIM = 8'hF0;
	localparam logic [7:0] MASK_INPUT_SETUP = 8'hFD;

	// Input setup and gain trim field positions
	localparam int BIT_LINE_SELECT = 7;
	localparam int BIT_SOURCE_HI = 6;
	localparam int BIT_SOURCE_LO = 5;
	localparam int BIT_DC_COUPLING = 4;
	localparam int BIT_IMPEDANCE_HI = 3;
	localparam int BIT_IMPEDANCE_LO = 2;
	localparam int BIT_AUTOGAIN = 0;
	localparam int GAIN_TRIM_HI = 7;
	localparam int GAIN_TRIM_LO = 4;

	// Volume: code 0 mutes; gain in half-dB units = (code - 201)
	localparam logic [7:0] VOLUME_MUTE_CODE = 8'h00;
	localparam logic [7:0] VOLUME_UNITY_CODE = 8'hC9;
	// Gain trim: tenth-dB units = (code - 8)
	localparam logic [3:0] GAIN_TRIM_ZERO_CODE = 4'h8;

	typedef enum logic [1:0]
	{
		SRC_ANALOG_DIFF = 2'b00,
		SRC_ANALOG_SINGLE = 2'b01,
		SRC_DIGITAL_MIC = 2'b10,
		SRC_RESERVED = 2'b11
	} source_t;

	typedef enum logic [1:0]
	{
		IMP_2K5 = 2'b00,
		IMP_10K = 2'b01,
		IMP_20K = 2'b10,
		IMP_RESERVED = 2'b11
	} impedance_t;
endpackage

// ---- design/phase_delay_line.sv ----
// Purpose: Delays a sample stream by a programmable count of modulator clock ticks
// Assumes: mod_tick is a one-cycle enable at the modulator rate
// Notes: Depth bounds the largest delay

`timescale 1ns/1ps
`default_nettype none

module phase_delay_line
#(
	parameter int WIDTH = 1,
	parameter int DEPTH = 256
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Stream
	input wire logic mod_tick,
	input wire logic [WIDTH-1:0] sample_in,
	input wire logic [7:0] delay_code,
	output logic [WIDTH-1:0] sample_out
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [7:0] wr_ptr;
	logic [7:0] next_wr_ptr;
	logic [WIDTH-1:0] next_sample_out;
	logic [7:0] rd_ptr;

	always_comb
	begin
		next_wr_ptr = wr_ptr;
		rd_ptr = wr_ptr - delay_code;
		next_sample_out = sample_out;
		if (mod_tick)
		begin
			next_wr_ptr = wr_ptr + 8'h01;
			// Zero delay passes the new sample straight through
			next_sample_out = (delay_code == 8'h00) ? sample_in : mem[rd_ptr];
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= 8'h00;
			sample_out <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			sample_out <= next_sample_out;
		end
	end

	// Memory has no reset; stale words appear just after reset or a delay change
	always_ff @(posedge sys_clk)
	begin
		if (mod_tick)
		begin
			mem[wr_ptr] <= sample_in;
		end
	end
endmodule // phase_delay_line

`default_nettype wire

// ---- design/adc_channel_config_regs.sv ----
// Purpose: Channel one volume, gain and phase trim plus channel two input setup registers
// Assumes: Control port decoder gives one-cycle write and read strobes with a byte address
// Notes: Read data is registered one cycle after the read strobe

`timescale 1ns/1ps
`default_nettype none

module adc_channel_config_regs
	import chan_cfg_pkg::*;
#(
	parameter int SAMPLE_W = 1,
	parameter int DELAY_DEPTH = 256
)
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register access from the control port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_hit,
	// Gain control qualifier from the gain control block
	input wire logic autogain_control_bit3,
	// Channel one modulator stream
	input wire logic mod_tick,
	input wire logic [SAMPLE_W-1:0] chan_one_sample_in,
	output logic [SAMPLE_W-1:0] chan_one_sample_delayed,
	// Channel one volume and trim decoded
	output logic [7:0] chan_one_volume_code,
	output logic chan_one_mute,
	output logic signed [8:0] chan_one_volume_half_db,
	output logic [3:0] chan_one_gain_trim_code,
	output logic signed [4:0] chan_one_gain_trim_tenth_db,
	output logic [7:0] chan_one_phase_delay_code,
	// Channel two input setup
	output logic chan_two_line_select,
	output logic [1:0] chan_two_source_select,
	output logic chan_two_analog_source,
	output logic chan_two_digital_mic,
	output logic chan_two_dc_coupling,
	output logic [1:0] chan_two_impedance_select,
	output logic chan_two_autogain_enable,
	output logic chan_two_autogain_active
);
	logic [7:0] chan_one_volume;
	logic [7:0] chan_one_gain_trim;
	logic [7:0] chan_one_phase_trim;
	logic [7:0] chan_two_input_setup;
	logic [7:0] next_chan_one_volume;
	logic [7:0] next_chan_one_gain_trim;
	logic [7:0] next_chan_one_phase_trim;
	logic [7:0] next_chan_two_input_setup;
	logic [7:0] next_reg_rdata;
	logic next_reg_hit;

	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	always_comb
	begin
		next_chan_one_volume = chan_one_volume;
		next_chan_one_gain_trim = chan_one_gain_trim;
		next_chan_one_phase_trim = chan_one_phase_trim;
		next_chan_two_input_setup = chan_two_input_setup;
		if (reg_wr)
		begin
			if (addr_is(reg_addr, OFF_CHAN_ONE_VOLUME))
			begin
				next_chan_one_volume = reg_wdata;
			end
			if (addr_is(reg_addr, OFF_CHAN_ONE_GAIN_TRIM))
			begin
				// Reserved low nibble never stored, so it always reads zero
				next_chan_one_gain_trim = reg_wdata & MASK_GAIN_TRIM;
			end
			if (addr_is(reg_addr, OFF_CHAN_ONE_PHASE_TRIM))
			begin
				next_chan_one_phase_trim = reg_wdata;
			end
			if (addr_is(reg_addr, OFF_CHAN_TWO_INPUT_SETUP))
			begin
				// Reserved codes are stored as written; software must avoid them
				next_chan_two_input_setup = reg_wdata & MASK_INPUT_SETUP;
			end
		end
	end

	always_comb
	begin
		next_reg_rdata = reg_rdata;
		next_reg_hit = 1'b0;
		if (reg_rd)
		begin
			next_reg_hit = 1'b1;
			if (addr_is(reg_addr, OFF_CHAN_ONE_VOLUME))
			begin
				next_reg_rdata = chan_one_volume;
			end
			else if (addr_is(reg_addr, OFF_CHAN_ONE_GAIN_TRIM))
			begin
				next_reg_rdata = chan_one_gain_trim;
			end
			else if (addr_is(reg_addr, OFF_CHAN_ONE_PHASE_TRIM))
			begin
				next_reg_rdata = chan_one_phase_trim;
			end
			else if (addr_is(reg_addr, OFF_CHAN_TWO_INPUT_SETUP))
			begin
				next_reg_rdata = chan_two_input_setup;
			end
			else
			begin
				// Other addresses belong to neighbouring banks
				next_reg_rdata = 8'h00;
				next_reg_hit = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			chan_one_volume <= RST_CHAN_ONE_VOLUME;
			chan_one_gain_trim <= RST_CHAN_ONE_GAIN_TRIM;
			chan_one_phase_trim <= RST_CHAN_ONE_PHASE_TRIM;
			chan_two_input_setup <= RST_CHAN_TWO_INPUT_SETUP;
			reg_rdata <= 8'h00;
			reg_hit <= 1'b0;
		end
		else
		begin
			chan_one_volume <= next_chan_one_volume;
			chan_one_gain_trim <= next_chan_one_gain_trim;
			chan_one_phase_trim <= next_chan_one_phase_trim;
			chan_two_input_setup <= next_chan_two_input_setup;
			reg_rdata <= next_reg_rdata;
			reg_hit <= next_reg_hit;
		end
	end

	// Channel one volume decode: code 201 is 0 dB, half-dB per code
	assign chan_one_volume_code = chan_one_volume;
	assign chan_one_mute = (chan_one_volume == VOLUME_MUTE_CODE);
	// Code 1 -> -200, 2 -> -199, 202 -> +1, 254 -> +53, 255 -> +54 half-dB
	assign chan_one_volume_half_db = chan_one_mute ? 9'sd0 :
		$signed({1'b0, chan_one_volume}) - $signed({1'b0, VOLUME_UNITY_CODE});

	// Gain trim decode: code 8 is 0 dB, tenth-dB per code, -8..+7
	assign chan_one_gain_trim_code = chan_one_gain_trim[GAIN_TRIM_HI:GAIN_TRIM_LO];
	assign chan_one_gain_trim_tenth_db = $signed({1'b0, chan_one_gain_trim_code})
		- $signed({1'b0, GAIN_TRIM_ZERO_CODE});

	assign chan_one_phase_delay_code = chan_one_phase_trim;

	// Modulator-rate delay line applying the phase trim
	phase_delay_line #(
		.WIDTH(SAMPLE_W),
		.DEPTH(DELAY_DEPTH)
	) u_phase_delay (
		.sys_clk(sys_clk),
		.rst(rst),
		.mod_tick(mod_tick),
		.sample_in(chan_one_sample_in),
		.delay_code(chan_one_phase_trim),
		.sample_out(chan_one_sample_delayed)
	);

	// Channel two setup fields
	assign chan_two_line_select = chan_two_input_setup[BIT_LINE_SELECT];
	assign chan_two_source_select =
		chan_two_input_setup[BIT_SOURCE_HI:BIT_SOURCE_LO];
	// Analog source flag lets pin muxing drop general pin one functions
	assign chan_two_analog_source = (chan_two_source_select == SRC_ANALOG_DIFF)
		|| (chan_two_source_select == SRC_ANALOG_SINGLE);
	assign chan_two_digital_mic = (chan_two_source_select == SRC_DIGITAL_MIC);
	// Coupling is gated to analog sources; impedance passes through for every source
	assign chan_two_dc_coupling =
		chan_two_input_setup[BIT_DC_COUPLING] & chan_two_analog_source;
	assign chan_two_impedance_select =
		chan_two_input_setup[BIT_IMPEDANCE_HI:BIT_IMPEDANCE_LO];
	assign chan_two_autogain_enable = chan_two_input_setup[BIT_AUTOGAIN];
	assign chan_two_autogain_active =
		chan_two_autogain_enable & autogain_control_bit3;
endmodule // adc_channel_config_regs

`default_nettype wire

// ---- dv/cfg_regs_monitor.sv ----
// Purpose: Port checker for the channel configuration register bank
// Assumes: Strobes are one-cycle pulses sampled on sys_clk
// Notes: Reads answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none
module cfg_regs_monitor
	import chan_cfg_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Register access
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic [DATA_W-1:0] reg_rdata,
	input wire logic reg_hit,
	// Settings
	input wire logic autogain_control_bit3,
	input wire logic [7:0] chan_one_volume_code,
	input wire logic chan_one_mute,
	input wire logic [3:0] chan_one_gain_trim_code,
	input wire logic [1:0] chan_two_source_select,
	input wire logic chan_two_autogain_enable,
	input wire logic chan_two_autogain_active
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire mapped = reg_addr >= 8'h3E && reg_addr <= 8'h41;
	sequence wr_vol; reg_wr && reg_addr == 8'h3E; endsequence
	sequence rd_vol; reg_rd && !reg_wr && reg_addr == 8'h3E; endsequence
	vol_readback_a: assert property (wr_vol ##1 rd_vol |=> reg_rdata == $past(reg_wdata, 2))
		else $error("volume read back differs");
	read_hit_a: assert property (reg_rd && mapped |=> reg_hit)
		else $error("mapped read without hit");
	unmapped_read_a: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 8'h00)
		else $error("unmapped read answered");
	vol_write_a: assert property (wr_vol |=> chan_one_volume_code == $past(reg_wdata))
		else $error("volume not stored");
	mute_level_a: assert property (chan_one_mute == (chan_one_volume_code == 8'h00))
		else $error("mute flag wrong");
	trim_write_a: assert property (reg_wr && reg_addr == 8'h3F |=>
		chan_one_gain_trim_code == $past(reg_wdata[7:4]))
		else $error("trim not stored");
	trim_reserved_a: assert property (reg_rd && reg_addr == 8'h3F |=> reg_rdata[3:0] == 4'h0)
		else $error("trim low nibble not zero");
	setup_reserved_a: assert property (reg_rd && reg_addr == 8'h41 |=> !reg_rdata[1])
		else $error("setup bit 1 not zero");
	source_write_a: assert property (reg_wr && reg_addr == 8'h41 |=>
		chan_two_source_select == $past(reg_wdata[6:5]))
		else $error("source not stored");
	autogain_gate_a: assert property (chan_two_autogain_active ==
		(chan_two_autogain_enable && autogain_control_bit3))
		else $error("gain control gating wrong");
endmodule // cfg_regs_monitor
bind adc_channel_config_regs cfg_regs_monitor cfg_regs_monitor_i (.sys_clk, .rst, .reg_wr,
	.reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .autogain_control_bit3,
	.chan_one_volume_code, .chan_one_mute, .chan_one_gain_trim_code, .chan_two_source_select,
	.chan_two_autogain_enable, .chan_two_autogain_active);
`default_nettype wire

// ---- dv/adc_channel_config_regs_bench.sv ----
// Purpose: Self-checking bench for the channel configuration register bank
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Reads are queued and checked by the watcher
`timescale 1ns/1ps
`default_nettype none
module adc_channel_config_regs_bench;
	import chan_cfg_pkg::*;
	logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, mod_tick = 0;
	logic autogain_control_bit3 = 0, pend = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, chan_one_sample_in = 0, d;
	logic [7:0] reg_rdata, chan_one_volume_code, chan_one_phase_delay_code, chan_one_sample_delayed;
	logic reg_hit, chan_one_mute, chan_two_line_select, chan_two_analog_source;
	logic chan_two_digital_mic, chan_two_dc_coupling, chan_two_autogain_enable;
	logic chan_two_autogain_active;
	logic signed [8:0] chan_one_volume_half_db;
	logic [3:0] chan_one_gain_trim_code;
	logic signed [4:0] chan_one_gain_trim_tenth_db;
	logic [1:0] chan_two_source_select, chan_two_impedance_select;
	logic [8:0] q[$];
	logic [7:0] h[$];
	logic [7:0] vc[7] = '{0, 1, 2, 201, 202, 254, 255};
	logic [3:0] tc[5] = '{0, 1, 8, 9, 15};
	logic [31:0] x = 32'h133b_b7aa;
	int errors = 0, n_checks = 0;
	adc_channel_config_regs #(.SAMPLE_W(8)) adc_channel_config_regs_i (
		.sys_clk(sys_clk),
		.rst(rst),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.reg_hit(reg_hit),
		.autogain_control_bit3(autogain_control_bit3),
		.mod_tick(mod_tick),
		.chan_one_sample_in(chan_one_sample_in),
		.chan_one_sample_delayed(chan_one_sample_delayed),
		.chan_one_volume_code(chan_one_volume_code),
		.chan_one_mute(chan_one_mute),
		.chan_one_volume_half_db(chan_one_volume_half_db),
		.chan_one_gain_trim_code(chan_one_gain_trim_code),
		.chan_one_gain_trim_tenth_db(chan_one_gain_trim_tenth_db),
		.chan_one_phase_delay_code(chan_one_phase_delay_code),
		.chan_two_line_select(chan_two_line_select),
		.chan_two_source_select(chan_two_source_select),
		.chan_two_analog_source(chan_two_analog_source),
		.chan_two_digital_mic(chan_two_digital_mic),
		.chan_two_dc_coupling(chan_two_dc_coupling),
		.chan_two_impedance_select(chan_two_impedance_select),
		.chan_two_autogain_enable(chan_two_autogain_enable),
		.chan_two_autogain_active(chan_two_autogain_active)
	);
	always #25 sys_clk = ~sys_clk;
	function logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task chk(input logic [8:0] s, e, input string n);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// One strobe per call; back-to-back calls keep the strobe up without a gap
	task acc(input logic w, input logic [7:0] a, v, e);
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = v;
		if (!w)
			q.push_back({a >= 8'h3E && a <= 8'h41, e});
		@(posedge sys_clk);
		#1;
	endtask
	task idle();
		reg_wr = 0;
		reg_rd = 0;
		@(posedge sys_clk);
		#1;
	endtask
	task tick(input int n, input int c);
		repeat (n)
		begin
			mod_tick = 1;
			chan_one_sample_in = 8'(rnd());
			h.push_back(chan_one_sample_in);
			@(posedge sys_clk);
			#1;
			mod_tick = 0;
			if (h.size() > c)
				chk(chan_one_sample_delayed, h[h.size() - 1 - c], "delay");
			@(posedge sys_clk);
			#1;
		end
	endtask
	task give_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge sys_clk)
	begin
		if (pend)
			chk({reg_hit, reg_rdata}, q.pop_front(), "read");
		pend = reg_rd;
	end
	initial
	begin
		repeat (3) @(posedge sys_clk);
		#1 rst = 0;
		acc(0, 8'h3E, 0, 8'hC9);
		acc(0, 8'h3F, 0, 8'h80);
		acc(0, 8'h40, 0, 8'h00);
		acc(0, 8'h41, 0, 8'h00);
		chk(chan_one_volume_half_db, 0, "unity");
		chk(chan_one_phase_delay_code, 8'h00, "phase reset");
		foreach (vc[i])
		begin
			acc(1, 8'h3E, vc[i], 0);
			chk(chan_one_mute, vc[i] == 0, "mute");
			chk(chan_one_volume_code, vc[i], "code");
			chk(chan_one_volume_half_db, 9'(vc[i] == 0 ? 0 : vc[i] - 201), "vol");
			acc(0, 8'h3E, 0, vc[i]);
		end
		foreach (tc[i])
		begin
			acc(1, 8'h3F, {tc[i], 4'h0}, 0);
			chk(9'(chan_one_gain_trim_tenth_db), 9'(tc[i] - 8), "trim");
			acc(0, 8'h3F, 0, {tc[i], 4'h0});
		end
		// Software keeps the reserved nibble at zero even for the top trim code
		acc(1, 8'h3F, 8'hF0, 0);
		acc(0, 8'h3F, 0, 8'hF0);
		acc(1, 8'h40, 8'hFF, 0);
		chk(chan_one_phase_delay_code, 8'hFF, "phase code");
		acc(0, 8'h40, 0, 8'hFF);
		acc(1, 8'h40, 8'h00, 0);
		idle();
		tick(4, 0);
		acc(1, 8'h40, 8'h05, 0);
		idle();
		tick(12, 5);
		for (int s = 0; s < 3; s++)
		begin
			x = rnd();
			autogain_control_bit3 = x[9];
			// Code three never used and reserved bit 1 kept at zero
			d = {x[7], 2'(s), x[4], 2'(s), 1'b0, x[0]};
			acc(1, 8'h41, d, 0);
			chk({chan_two_line_select, chan_two_source_select, chan_two_digital_mic,
				chan_two_dc_coupling, chan_two_impedance_select, chan_two_autogain_enable,
				chan_two_autogain_active}, {d[7:5], s == 2, d[4] && s < 2, d[3:2], d[0],
				d[0] && x[9]}, "setup");
			chk(chan_two_analog_source, s < 2, "analog");
			acc(0, 8'h41, 0, d & 8'hFD);
		end
		acc(1, 8'h42, 8'hFF, 0);
		acc(0, 8'h42, 0, 0);
		acc(0, 8'h3D, 0, 0);
		acc(0, 8'h41, 0, d & 8'hFD);
		idle();
		for (int i = 0; i < 5 && q.size() > 0; i++)
			@(posedge sys_clk);
		if (q.size() > 0)
			errors++;
		give_verdict();
	end
endmodule // adc_channel_config_regs_bench
`default_nettype wire
